// *** verilog/fifo_pkg.sv ***
/*
  Constants, types and register map of the flagged first-in first-out buffer.
  Assumes one core clock; the write and read clocks arrive as sampled inputs.
*/
package fifo_pkg;
  localparam int DEPTH_DEFAULT = 4096;
  localparam int WORD_W = 18;
  localparam int OFFSET_W = 12;
  localparam int BUS_ADDR_W = 4;
  // Register byte offsets on the bus.
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_EMPTY_OFFSET = 4'h4;
  localparam logic [3:0] REG_FULL_OFFSET = 4'h8;
  // Status register field positions.
  localparam int ST_EMPTY_N = 0;
  localparam int ST_ALMOST_EMPTY_N = 1;
  localparam int ST_HALF_FULL_N = 2;
  localparam int ST_ALMOST_FULL_N = 3;
  localparam int ST_FULL_N = 4;
  localparam int ST_DEPTH_EXPAND = 5;
  localparam int ST_WRITE_TOKEN = 6;
  localparam int ST_READ_TOKEN = 7;
  localparam int ST_COUNT_LSB = 16;
  // Offset reset values by depth.
  localparam logic [11:0] OFFSET_RST_256 = 12'h01F;
  localparam logic [11:0] OFFSET_RST_512 = 12'h03F;
  localparam logic [11:0] OFFSET_RST_DEEP = 12'h07F;
  localparam logic [31:0] BUS_UNMAPPED_DATA = 32'h0000_0000;

  typedef enum logic [0:0] {LOAD_EMPTY = 1'b0, LOAD_FULL = 1'b1} load_step_t;

  // Offset reset value for a given depth.
  function automatic logic [11:0] default_offset(input int depth);
    if (depth == 256)
    begin
      return OFFSET_RST_256;
    end
    else if (depth == 512)
    begin
      return OFFSET_RST_512;
    end
    return OFFSET_RST_DEEP;
  endfunction
endpackage

// *** verilog/dual_clock_flagged_fifo.sv ***
/*
  Flagged first-in first-out buffer with offset registers, daisy-chain depth
  expansion and an Avalon-MM slave for status and offsets.
  Assumes all inputs, including the write and read clock pins, are synchronous
  to core_clk, which runs faster than both pin clocks.
*/
// Implementation choices: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
module dual_clock_flagged_fifo
  import fifo_pkg::*;
#(
  parameter int DEPTH = DEPTH_DEFAULT
)
(
  // Core clock and reset.
  input wire logic core_clk,
  input wire logic nrst,
  // Write port.
  input wire logic write_clock,
  input wire logic write_enable_n,
  input wire logic [WORD_W-1:0] write_data,
  // Read port.
  input wire logic read_clock,
  input wire logic read_enable_n,
  input wire logic output_enable_n,
  output logic [WORD_W-1:0] read_data,
  output logic read_data_oe,
  // Control and expansion.
  input wire logic master_reset_n,
  input wire logic offset_load_n,
  input wire logic first_load_select,
  input wire logic write_chain_in,
  input wire logic read_chain_in,
  output logic write_chain_out,
  output logic read_chain_out,
  // Flags.
  output logic full_flag_n,
  output logic empty_flag_n,
  output logic almost_full_flag_n,
  output logic almost_empty_flag_n,
  output logic half_full_flag_n,
  // Avalon-MM slave.
  input wire logic [BUS_ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest
);
  localparam int ADDR_W = $clog2(DEPTH);
  localparam int CNT_W = ADDR_W + 1;
  localparam logic [CNT_W-1:0] FULL_COUNT = CNT_W'(DEPTH);
  localparam logic [CNT_W-1:0] HALF_COUNT = CNT_W'(DEPTH / 2);
  localparam logic [ADDR_W-1:0] LAST_ADDR = ADDR_W'(DEPTH - 1);
  localparam logic [OFFSET_W-1:0] OFFSET_RST = default_offset(DEPTH);

  logic [WORD_W-1:0] storage [DEPTH];
  logic [CNT_W-1:0] wrPtr;
  logic [CNT_W-1:0] rdPtr;
  logic [CNT_W-1:0] next_wrPtr;
  logic [CNT_W-1:0] next_rdPtr;
  logic [CNT_W-1:0] next_count;
  logic [CNT_W-1:0] count;
  logic [OFFSET_W-1:0] emptyOffset;
  logic [OFFSET_W-1:0] fullOffset;
  logic wrClkPrev;
  logic rdClkPrev;
  logic wrEdge;
  logic rdEdge;
  logic doWrite;
  logic doRead;
  logic loadWrite;
  logic loadRead;
  logic depthExpand;
  logic strapTaken;
  logic writeToken;
  logic readToken;
  logic halfFull;
  logic wrChainPulse;
  logic rdChainPulse;
  load_step_t wrStep;
  load_step_t rdStep;
  logic busAck;
  logic busReq;
  logic busWriteEmpty;
  logic busWriteFull;

  // Rising edges of the pin clocks, seen at the core clock.
  assign wrEdge = write_clock & ~wrClkPrev;
  assign rdEdge = read_clock & ~rdClkPrev;

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wrClkPrev <= 1'b0;
      rdClkPrev <= 1'b0;
    end
    else
    begin
      wrClkPrev <= write_clock;
      rdClkPrev <= read_clock;
    end
  end

  // Accepted operations; offset loads take the place of buffer access.
  assign doWrite = wrEdge & ~write_enable_n & offset_load_n & full_flag_n
    & writeToken;
  assign doRead = rdEdge & ~read_enable_n & offset_load_n & empty_flag_n
    & readToken;
  assign loadWrite = wrEdge & ~write_enable_n & ~offset_load_n;
  assign loadRead = rdEdge & ~read_enable_n & ~offset_load_n;

  // Pointer arithmetic and the fill level after this cycle.
  assign next_wrPtr = doWrite ? wrPtr + 1'b1 : wrPtr;
  assign next_rdPtr = doRead ? rdPtr + 1'b1 : rdPtr;
  assign next_count = next_wrPtr - next_rdPtr;
  assign count = wrPtr - rdPtr;

  // Write and read pointers, cleared by master reset.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
    end
    else if (!master_reset_n)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
    end
    else
    begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
    end
  end

  // Storage array of DEPTH words; written only on an accepted write.
  always_ff @(posedge core_clk)
  begin
    if (doWrite)
    begin
      storage[wrPtr[ADDR_W-1:0]] <= write_data;
    end
  end

  // Output register: next word, offset contents, or held value.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      read_data <= '0;
    end
    else if (doRead)
    begin
      read_data <= storage[rdPtr[ADDR_W-1:0]];
    end
    else if (loadRead)
    begin
      if (rdStep == LOAD_EMPTY)
      begin
        read_data <= {(WORD_W - OFFSET_W)'(0), emptyOffset};
      end
      else
      begin
        read_data <= {(WORD_W - OFFSET_W)'(0), fullOffset};
      end
    end
  end

  // The bus drives only while output enable is low.
  assign read_data_oe = ~output_enable_n;

  // Offset load sequencers; they restart whenever load is released.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wrStep <= LOAD_EMPTY;
      rdStep <= LOAD_EMPTY;
    end
    else
    begin
      if (offset_load_n || !master_reset_n)
      begin
        wrStep <= LOAD_EMPTY;
      end
      else if (loadWrite)
      begin
        case (wrStep)
          LOAD_EMPTY: wrStep <= LOAD_FULL;
          LOAD_FULL: wrStep <= LOAD_EMPTY;
          default: wrStep <= LOAD_EMPTY;
        endcase
      end
      if (offset_load_n || !master_reset_n)
      begin
        rdStep <= LOAD_EMPTY;
      end
      else if (loadRead)
      begin
        case (rdStep)
          LOAD_EMPTY: rdStep <= LOAD_FULL;
          LOAD_FULL: rdStep <= LOAD_EMPTY;
          default: rdStep <= LOAD_EMPTY;
        endcase
      end
    end
  end

  // Offset registers: a bus write lands only at the edge where waitrequest is low.
  // Pin loads win over bus writes in the same cycle.
  assign busReq = (read | write) & ~busAck;
  assign busWriteEmpty = write & busAck & (address == REG_EMPTY_OFFSET);
  assign busWriteFull = write & busAck & (address == REG_FULL_OFFSET);

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      emptyOffset <= OFFSET_RST;
      fullOffset <= OFFSET_RST;
    end
    else if (!master_reset_n)
    begin
      emptyOffset <= OFFSET_RST;
      fullOffset <= OFFSET_RST;
    end
    else if (loadWrite)
    begin
      if (wrStep == LOAD_EMPTY)
      begin
        emptyOffset <= write_data[OFFSET_W-1:0];
      end
      else
      begin
        fullOffset <= write_data[OFFSET_W-1:0];
      end
    end
    else
    begin
      if (busWriteEmpty)
      begin
        emptyOffset <= writedata[OFFSET_W-1:0];
      end
      if (busWriteFull)
      begin
        fullOffset <= writedata[OFFSET_W-1:0];
      end
    end
  end

  // Write-side flags follow the write clock.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      full_flag_n <= 1'b1;
      almost_full_flag_n <= 1'b1;
      halfFull <= 1'b0;
    end
    else if (!master_reset_n)
    begin
      full_flag_n <= 1'b1;
      almost_full_flag_n <= 1'b1;
      halfFull <= 1'b0;
    end
    else if (wrEdge)
    begin
      full_flag_n <= (next_count != FULL_COUNT);
      almost_full_flag_n <= (13'(FULL_COUNT - next_count) > 13'(fullOffset));
      halfFull <= (next_count > HALF_COUNT);
    end
  end

  // Read-side flags follow the read clock.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      empty_flag_n <= 1'b0;
      almost_empty_flag_n <= 1'b0;
    end
    else if (!master_reset_n)
    begin
      empty_flag_n <= 1'b0;
      almost_empty_flag_n <= 1'b0;
    end
    else if (rdEdge)
    begin
      empty_flag_n <= (next_count != '0);
      almost_empty_flag_n <= (13'(next_count) > 13'(emptyOffset));
    end
  end

  // Expansion mode is caught from the write chain input after reset release.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      strapTaken <= 1'b0;
      depthExpand <= 1'b0;
    end
    else if (!master_reset_n)
    begin
      strapTaken <= 1'b0;
    end
    else if (!strapTaken)
    begin
      strapTaken <= 1'b1;
      depthExpand <= write_chain_in;
    end
  end

  // Write ownership passes along the chain on the last location written.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      writeToken <= 1'b0;
      wrChainPulse <= 1'b0;
    end
    else if (!master_reset_n || !strapTaken)
    begin
      writeToken <= ~first_load_select;
      wrChainPulse <= 1'b0;
    end
    else if (!depthExpand)
    begin
      writeToken <= 1'b1;
      wrChainPulse <= 1'b0;
    end
    else if (doWrite && wrPtr[ADDR_W-1:0] == LAST_ADDR)
    begin
      writeToken <= 1'b0;
      wrChainPulse <= 1'b1;
    end
    else if (wrEdge)
    begin
      wrChainPulse <= 1'b0;
      if (!write_chain_in)
      begin
        writeToken <= 1'b1;
      end
    end
  end

  // Read ownership passes along the chain on the last location read.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      readToken <= 1'b0;
      rdChainPulse <= 1'b0;
    end
    else if (!master_reset_n || !strapTaken)
    begin
      readToken <= ~first_load_select;
      rdChainPulse <= 1'b0;
    end
    else if (!depthExpand)
    begin
      readToken <= 1'b1;
      rdChainPulse <= 1'b0;
    end
    else if (doRead && rdPtr[ADDR_W-1:0] == LAST_ADDR)
    begin
      readToken <= 1'b0;
      rdChainPulse <= 1'b1;
    end
    else if (rdEdge)
    begin
      rdChainPulse <= 1'b0;
      if (!read_chain_in)
      begin
        readToken <= 1'b1;
      end
    end
  end

  // Shared half-full pin carries the write chain in depth expansion.
  assign write_chain_out = ~wrChainPulse;
  assign half_full_flag_n = depthExpand ? ~wrChainPulse : ~halfFull;
  assign read_chain_out = ~rdChainPulse;

  // Bus slave: one wait state, then the answer at the next edge.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      busAck <= 1'b0;
      readdata <= '0;
    end
    else
    begin
      busAck <= busReq;
      if (read && busReq)
      begin
        case (address)
          REG_STATUS:
          begin
            readdata <= '0;
            readdata[ST_EMPTY_N] <= empty_flag_n;
            readdata[ST_ALMOST_EMPTY_N] <= almost_empty_flag_n;
            readdata[ST_HALF_FULL_N] <= ~halfFull;
            readdata[ST_ALMOST_FULL_N] <= almost_full_flag_n;
            readdata[ST_FULL_N] <= full_flag_n;
            readdata[ST_DEPTH_EXPAND] <= depthExpand;
            readdata[ST_WRITE_TOKEN] <= writeToken;
            readdata[ST_READ_TOKEN] <= readToken;
            readdata[ST_COUNT_LSB +: CNT_W] <= count;
          end
          REG_EMPTY_OFFSET: readdata <= {20'h0_0000, emptyOffset};
          REG_FULL_OFFSET: readdata <= {20'h0_0000, fullOffset};
          default: readdata <= BUS_UNMAPPED_DATA;
        endcase
      end
    end
  end

  assign waitrequest = busReq;

endmodule // dual_clock_flagged_fifo

// *** verification/fifo_flag_checker.sv ***
/*
  Concurrent checks on the flagged buffer's pins and flags.
  Assumes single-device use with pin clocks sampled by core_clk.
*/
`timescale 1ns/1ps
module fifo_flag_checker
  import fifo_pkg::*;
(
  // Clock and resets.
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic master_reset_n,
  // Pin clocks and controls.
  input wire logic write_clock,
  input wire logic read_clock,
  input wire logic read_enable_n,
  input wire logic output_enable_n,
  input wire logic offset_load_n,
  input wire logic write_chain_in,
  // Outputs under watch.
  input wire logic [WORD_W-1:0] read_data,
  input wire logic read_data_oe,
  input wire logic read_chain_out,
  input wire logic full_flag_n,
  input wire logic empty_flag_n,
  input wire logic almost_full_flag_n,
  input wire logic almost_empty_flag_n,
  input wire logic half_full_flag_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);

  // Output drive, data holding, flag timing, flag consistency and read chain idling.
  oe_follow_a: assert property (read_data_oe == !output_enable_n)
    else $error("output drive does not follow output enable");
  mreset_flags_a: assert property (!master_reset_n |=> full_flag_n && almost_full_flag_n
    && !empty_flag_n && !almost_empty_flag_n) else $error("flags wrong after master reset");
  hold_data_a: assert property ($past(read_enable_n) && $past(master_reset_n)
    |-> $stable(read_data)) else $error("output word moved without a read");
  empty_hold_a: assert property ($past(!empty_flag_n && offset_load_n && master_reset_n)
    |-> $stable(read_data)) else $error("output word moved while empty");
  full_sync_a: assert property ($changed(full_flag_n) |->
    ($past(write_clock) && !$past(write_clock, 2)) || !$past(master_reset_n))
    else $error("full flag moved off a write edge");
  empty_sync_a: assert property ($changed(empty_flag_n) |->
    ($past(read_clock) && !$past(read_clock, 2)) || !$past(master_reset_n))
    else $error("empty flag moved off a read edge");
  full_implies_a: assert property (!full_flag_n |->
    !almost_full_flag_n && !half_full_flag_n) else $error("full without partial flags");
  empty_implies_a: assert property (!empty_flag_n |-> !almost_empty_flag_n)
    else $error("empty without almost empty");
  chain_idle_a: assert property (!write_chain_in && $past(!write_chain_in)
    |-> read_chain_out) else $error("read chain pulse in single use");

  // Main scenarios reached.
  cover property (!full_flag_n);
  cover property ($rose(empty_flag_n));
  cover property (!offset_load_n && !read_enable_n);
endmodule // fifo_flag_checker

bind dual_clock_flagged_fifo fifo_flag_checker u_fifo_flag_checker (
  .core_clk(core_clk), .nrst(nrst), .master_reset_n(master_reset_n),
  .write_clock(write_clock), .read_clock(read_clock), .read_enable_n(read_enable_n),
  .output_enable_n(output_enable_n), .offset_load_n(offset_load_n),
  .write_chain_in(write_chain_in), .read_data(read_data), .read_data_oe(read_data_oe),
  .read_chain_out(read_chain_out), .full_flag_n(full_flag_n), .empty_flag_n(empty_flag_n),
  .almost_full_flag_n(almost_full_flag_n), .almost_empty_flag_n(almost_empty_flag_n),
  .half_full_flag_n(half_full_flag_n));

// *** verification/pin_clock_source.sv ***
/*
  Free-running write and read pin clocks of the two controllers.
  Assumes core_clk runs faster than twice either pin clock.
*/
`timescale 1ns/1ps
module pin_clock_source #(
  parameter int WRITE_HALF = 2,
  parameter int READ_HALF = 3
)
(
  // Core clock and reset.
  input wire logic core_clk,
  input wire logic nrst,
  // Pin clocks.
  output logic write_clock,
  output logic read_clock
);
  int wCnt;
  int rCnt;

  // Unequal half periods keep the two pin clocks out of step.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wCnt <= 0;
      rCnt <= 0;
      write_clock <= 1'b0;
      read_clock <= 1'b0;
    end
    else
    begin
      wCnt <= (wCnt == WRITE_HALF - 1) ? 0 : wCnt + 1;
      rCnt <= (rCnt == READ_HALF - 1) ? 0 : rCnt + 1;
      write_clock <= (wCnt == WRITE_HALF - 1) ? !write_clock : write_clock;
      read_clock <= (rCnt == READ_HALF - 1) ? !read_clock : read_clock;
    end
  end
endmodule // pin_clock_source

// *** verification/tb_top.sv ***
/*
  Self-checking bench for the flagged buffer: pin traffic, offsets, flags, bus.
  Assumes a 256-deep build and free-running pin clocks from the partner.
*/
`timescale 1ns/1ps
module tb_top;
  import fifo_pkg::*;
  localparam int DEPTH = 256;
  localparam logic [31:0] DEF_OFF = 32'h0000_001F;
  logic coreClk, nrst, wrClk, rdClk, wrEnN, rdEnN, outEnN, mrstN, loadN;
  logic read, write, waitrequest, oe, fullN, emptyN, aFullN, aEmptyN, halfN;
  logic wrXo, rdXo;
  logic [WORD_W-1:0] wrData, rdData, got, prev;
  logic [3:0] address;
  logic [31:0] writedata, readdata, q;
  logic [11:0] offE, offF;
  logic [WORD_W-1:0] mem[$];
  int badCount, cmpCount, seed;

  // Device under test, single use.
  dual_clock_flagged_fifo #(.DEPTH(DEPTH)) u_dual_clock_flagged_fifo (
    .core_clk(coreClk), .nrst(nrst), .write_clock(wrClk), .write_enable_n(wrEnN),
    .write_data(wrData), .read_clock(rdClk), .read_enable_n(rdEnN),
    .output_enable_n(outEnN), .read_data(rdData), .read_data_oe(oe),
    .master_reset_n(mrstN), .offset_load_n(loadN), .first_load_select(1'b0),
    .write_chain_in(1'b0), .read_chain_in(1'b0),
    .write_chain_out(wrXo), .read_chain_out(rdXo), .full_flag_n(fullN), .empty_flag_n(emptyN),
    .almost_full_flag_n(aFullN), .almost_empty_flag_n(aEmptyN), .half_full_flag_n(halfN),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest));
  pin_clock_source u_pin_clock_source (.core_clk(coreClk), .nrst(nrst),
    .write_clock(wrClk), .read_clock(rdClk));

  // Core clock.
  initial
  begin
    coreClk = 1'b0;
    forever #25 coreClk = ~coreClk;
  end

  // Compares one value and counts it.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp)
    begin
      badCount++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic reportAndStop();
    $display("compares %0d mismatches %0d", cmpCount, badCount);
    if (badCount == 0 && cmpCount > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // One bus transfer, held until waitrequest is seen low at a rising edge.
  // Read data is taken at that same edge; a stuck slave counts as a mismatch.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge coreClk);
    address <= a;
    writedata <= d;
    read <= !wr;
    write <= wr;
    do
      @(posedge coreClk);
    while (waitrequest !== 1'b0 && ++n < 40);
    if (n >= 40)
      badCount++;
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  // Waits for a core edge at which the chosen pin clock was sampled at a level.
  task automatic waitPin(input bit rd, input logic lvl);
    do
      @(posedge coreClk);
    while ((rd ? rdClk : wrClk) !== lvl);
  endtask

  // One word on a write-clock rise.
  task automatic pinWrite(input logic [WORD_W-1:0] d);
    waitPin(0, 1'b0);
    wrEnN <= 1'b0;
    wrData <= d;
    waitPin(0, 1'b1);
    wrEnN <= 1'b1;
    @(negedge coreClk);
  endtask

  // One read-clock rise with read enable low; the empty flag gets time to refresh.
  task automatic pinRead();
    for (int n = 0; n < 40 && emptyN !== 1'b1; n++)
      @(posedge coreClk);
    waitPin(1, 1'b0);
    rdEnN <= 1'b0;
    outEnN <= 1'($random(seed));
    waitPin(1, 1'b1);
    rdEnN <= 1'b1;
    @(negedge coreClk);
    got = rdData;
    check(32'(oe), 32'(!outEnN));
  endtask

  // Expected full, almost-full and half-full flags for a word count.
  function automatic logic [2:0] wFlags(input int n);
    return {n != DEPTH, DEPTH - n > int'(offF), n <= DEPTH / 2};
  endfunction

  // Main sequence.
  initial
  begin
    seed = 32'h5e8f_54bb;
    {nrst, mrstN, read, write, outEnN} = '0;
    {wrEnN, rdEnN, loadN} = 3'b111;
    {address, writedata, wrData, badCount, cmpCount} = '0;
    repeat (16) @(posedge coreClk);
    nrst <= 1'b1;
    repeat (4) @(posedge coreClk);
    mrstN <= 1'b1;
    repeat (4) @(posedge coreClk);
    @(negedge coreClk);
    check(32'({fullN, aFullN, aEmptyN, emptyN}), 32'h0000_000C);
    bus(0, REG_EMPTY_OFFSET, 0);
    check(q, DEF_OFF);
    bus(1, 4'hC, $random(seed));
    bus(0, 4'hC, 0);
    check(q, 32'h0000_0000);
    offE = 12'(($random(seed) & 32'h3F) + 1);
    offF = 12'(($random(seed) & 32'h3F) + 1);
    loadN <= 1'b0;
    pinWrite({6'h3F, offE});
    pinWrite({6'h3F, offF});
    @(posedge coreClk);
    loadN <= 1'b1;
    @(posedge coreClk);
    loadN <= 1'b0;
    pinRead();
    check(32'(got[11:0]), 32'(offE));
    pinRead();
    check(32'(got[11:0]), 32'(offF));
    @(posedge coreClk);
    loadN <= 1'b1;
    bus(0, REG_FULL_OFFSET, 0);
    check(q, 32'(offF));
    offE = 12'(($random(seed) & 32'h3F) + 2);
    bus(1, REG_EMPTY_OFFSET, 32'(offE));
    bus(0, REG_EMPTY_OFFSET, 0);
    check(q, 32'(offE));
    for (int i = 1; i <= DEPTH; i++)
    begin
      mem.push_back(18'($random(seed)));
      pinWrite(mem[$]);
      check(32'({fullN, aFullN, halfN}), 32'(wFlags(i)));
    end
    pinWrite(18'($random(seed)));
    check(32'({fullN, aFullN, halfN}), 32'(wFlags(DEPTH)));
    for (int i = DEPTH - 1; i >= 0; i--)
    begin
      pinRead();
      check(32'(got), 32'(mem.pop_front()));
      check(32'({emptyN, aEmptyN}), 32'({i != 0, i > int'(offE)}));
    end
    prev = got;
    pinRead();
    check(32'(got), 32'(prev));
    pinWrite(18'h1_2345);
    pinWrite(18'h0_6789);
    @(posedge coreClk);
    mrstN <= 1'b0;
    @(posedge coreClk);
    mrstN <= 1'b1;
    @(negedge coreClk);
    check(32'({fullN, aFullN, aEmptyN, emptyN}), 32'h0000_000C);
    bus(0, REG_FULL_OFFSET, 0);
    check(q, DEF_OFF);
    bus(0, REG_STATUS, 0);
    check(q, 32'h0000_00DC);
    check(32'({wrXo, rdXo, halfN}), 32'h0000_0007);
    pinWrite(18'h2_ABCD);
    pinRead();
    check(32'(got), 32'h0002_ABCD);
    reportAndStop();
  end

  // Watchdog cuts a hang short.
  initial
  begin
    #(60000 * 50);
    badCount++;
    reportAndStop();
  end
endmodule // tb_top
